// >>> bench/pcc_tb_top.sv
`timescale 1ns/100ps
module pcc_tb_top;
   import pcc_pkg::*;
   // ***************************************************************
   // short gate keeps the run brief; counts are per gate, not kHz
   // ***************************************************************
   localparam int unsigned GATE  = 100;
   // five hclk cycles a reference period divide the gate evenly
   localparam int unsigned REF_N = GATE / 5;
   logic        hclk;
   logic        hresetn;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic        hready;
   logic        hreadyout;
   logic        hresp;
   logic [31:0] hrdata;
   logic        reference_input_clock;
   pcc_ctrl_t   ccw;
   logic [2:0]  core_div_ratio;
   logic        core_from_loop;
   logic [31:0] rd;
   int          fails;
   int          checked;

   assign hready = hreadyout;

   pcc_top #(.MEAS_LEN(GATE)) dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .reference_input_clock(reference_input_clock), .clock_control_word(ccw),
      .core_div_ratio(core_div_ratio), .core_from_loop(core_from_loop)
   );

   initial begin
      hclk = 1'b0;
      forever #4 hclk = ~hclk;
   end
   initial begin
      reference_input_clock = 1'b0;
      #3;
      forever #20 reference_input_clock = ~reference_input_clock;
   end

   // ***************************************************************
   // bus and checking helpers
   // ***************************************************************
   task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd,
                      output logic [31:0] r);
      hsel   <= 1'b1;
      haddr  <= a;
      hwrite <= w;
      htrans <= 2'b10;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge hclk); while (hready !== 1'b1);
      r = hrdata;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic meas(input logic [7:0] off, input logic [31:0] exp, input string what);
      ahb(1'b0, {24'h00_0000, off}, 32'h0, rd);
      check(what, rd, exp);
   endtask

   // status flags from the window limits and the counts that the gate holds
   function automatic logic [31:0] exp_status(input logic [31:0] rf,
                                              input logic [31:0] dv,
                                              input logic [31:0] lp,
                                              input logic [31:0] cr,
                                              input logic [31:0] n);
      logic [31:0] hi;
      logic [31:0] s;
      hi = (DIVIN_MAX_KHZ * n > REF_MAX_KHZ) ? REF_MAX_KHZ : DIVIN_MAX_KHZ * n;
      s  = 32'h0000_0000;
      s[ST_VALID]     = 1'b1;
      s[ST_REF_BAD]   = (rf < DIVIN_MIN_KHZ * n) || (rf > hi);
      s[ST_DIVIN_BAD] = (dv < DIVIN_MIN_KHZ) || (dv > DIVIN_MAX_KHZ);
      s[ST_LOOP_BAD]  = (lp < LOOP_MIN_KHZ) || (lp > LOOP_MAX_KHZ);
      s[ST_CORE_OVER] = cr > CORE_MAX_KHZ;
      return s;
   endfunction

   // two full gates so the latched counts see only the new setting
   task automatic settle();
      repeat (2 * GATE + 10) @(posedge hclk);
   endtask

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // ***************************************************************
   // scenarios
   // ***************************************************************
   task automatic t_reset_map();
      ahb(1'b0, 32'h0, 32'h0, rd);
      check("ctrl reset", rd, 32'h0000_1000);
      check("word reset", {17'h0_0000, ccw}, {17'h0_0000, RST_CTRL});
      check("ratio reset", {29'h0, core_div_ratio}, 32'h0);
      ahb(1'b1, 32'h0000_0100, 32'h0000_7FFF, rd);
      ahb(1'b1, 32'h0000_0018, 32'h0000_7FFF, rd);
      meas(8'h18, 32'h0, "unmapped read");
      ahb(1'b0, 32'h0000_0100, 32'h0, rd);
      check("upper read", rd, 32'h0);
      meas(OFF_CTRL, 32'h0000_1000, "ctrl kept");
   endtask

   task automatic t_predivide();
      logic [3:0] codes [6] = '{4'h0, 4'h1, 4'h3, 4'h4, 4'h9, 4'hF};
      logic [3:0] d;
      for (int i = 0; i < 6; i++) begin
         d = (codes[i] > PREDIV_MAX) ? PREDIV_MAX : codes[i];
         ahb(1'b1, 32'h0, {20'h0_0000, 8'h02, codes[i]}, rd);
         meas(OFF_CTRL, {20'h0_0000, 8'h02, d}, "predivide field");
         settle();
         meas(OFF_REF_KHZ, REF_N, "ref count");
         meas(OFF_DIV_KHZ, REF_N / (d + 1), "div count");
         meas(OFF_LOOP_KHZ, 3 * (REF_N / (d + 1)), "loop count");
         meas(OFF_CORE_KHZ, REF_N, "core from ref");
      end
   endtask

   task automatic t_source();
      logic [1:0]  s;
      logic        r;
      logic [2:0]  q;
      logic [31:0] core;
      logic [31:0] loop;
      logic [31:0] st;
      for (int i = 0; i < 8; i++) begin
         s = i[2:1];
         r = i[0];
         q = (s == SRC_VCO) ? (r ? 3'h1 : 3'h2) : (s == SRC_VCO_HALF) ? (r ? 3'h2 : 3'h4) : 3'h0;
         loop = (REF_N / 2) * 24;
         core = (q == 3'h0) ? REF_N : loop / q;
         st   = exp_status(REF_N, REF_N / 2, loop, core, 32'h0000_0002);
         // 25 MHz reference, /2 then x24: 12.5 MHz in, 300 MHz loop, core at most 300 MHz
         // no faster clock leaves here, so the derived clocks stay low
         ahb(1'b1, 32'h0, {17'h0_0000, s, r, 8'h17, 4'h1}, rd);
         settle();
         check("word port", {17'h0_0000, ccw}, {17'h0_0000, s, r, 8'h17, 4'h1});
         check("ratio port", {29'h0, core_div_ratio}, {29'h0, q});
         check("loop select", {31'h0, core_from_loop}, {31'h0, s[0]});
         meas(OFF_LOOP_KHZ, loop, "loop count");
         meas(OFF_CORE_KHZ, core, "core count");
         meas(OFF_STATUS, st, "status flags");
      end
   endtask

   initial begin
      hresetn = 1'b0;
      hsel    = 1'b0;
      haddr   = 32'h0;
      htrans  = 2'b00;
      hwrite  = 1'b0;
      hsize   = 3'b010;
      hwdata  = 32'h0;
      fails   = 0;
      checked = 0;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_reset_map();
      t_predivide();
      t_source();
      end_of_test();
   end

   initial begin
      #100_000;
      fails++;
      end_of_test();
   end
endmodule

// >>> bench/pcc_top_asserts.sv
`timescale 1ns/100ps
module pcc_top_chk
   import pcc_pkg::*;
#(
   parameter int unsigned MEAS_LEN = MEAS_CYCLES  // gate length
) (
   input wire logic               hclk,                   // clock
   input wire logic               hresetn,                // reset
   input wire logic               hsel,                   // select
   input wire logic [31:0]        haddr,                  // address
   input wire logic [1:0]         htrans,                 // transfer
   input wire logic               hwrite,                 // write
   input wire logic [2:0]         hsize,                  // size
   input wire logic [31:0]        hwdata,                 // write data
   input wire logic               hready,                 // ready in
   input wire logic               hreadyout,              // ready out
   input wire logic               hresp,                  // response
   input wire logic [31:0]        hrdata,                 // read data
   input wire logic               reference_input_clock,  // reference
   input wire pcc_pkg::pcc_ctrl_t clock_control_word,     // control
   input wire logic [2:0]         core_div_ratio,         // division
   input wire logic               core_from_loop          // loop source
);
   logic take;
   logic ctrl_hit;
   logic bad_addr;
   assign take     = hsel && htrans[1] && hready;
   assign ctrl_hit = (haddr == 32'h0000_0000);
   assign bad_addr = (haddr[31:8] != 24'h00_0000) || (haddr[1:0] != 2'b00)
                     || (haddr[7:0] > OFF_CORE_KHZ);

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   // ***************************************************************
   // register bus
   // ***************************************************************
   sequence s_ctrl_wr;
      take && hwrite && ctrl_hit ##1 1'b1;
   endsequence
   sequence s_ctrl_rd;
      take && !hwrite && ctrl_hit;
   endsequence

   chk_resp_okay: assert property (hresp == 1'b0) else $error("response not okay");
   chk_zero_wait: assert property ($past(hresetn) |-> hreadyout) else $error("wait state seen");
   chk_ctrl_update: assert property (s_ctrl_wr |=> clock_control_word[14:4] == $past(hwdata[14:4]))
      else $error("control word not updated");
   chk_prediv_sat: assert property (s_ctrl_wr |=> clock_control_word.input_predivide_field ==
      (($past(hwdata[3:0]) > PREDIV_MAX) ? PREDIV_MAX : $past(hwdata[3:0])))
      else $error("predivide code wrong");
   chk_ctrl_hold: assert property ($past(hresetn) && !$past(take && hwrite && ctrl_hit, 2)
      |-> $stable(clock_control_word)) else $error("control word changed unasked");
   chk_ctrl_read: assert property (s_ctrl_rd |=> hrdata == {17'h0_0000, clock_control_word})
      else $error("control read wrong");
   chk_unmapped_read: assert property (take && !hwrite && bad_addr |=> hrdata == 32'h0000_0000)
      else $error("unmapped read not zero");

   // ***************************************************************
   // core source and division
   // ***************************************************************
   property p_ratio(logic [1:0] s, logic r, logic [2:0] q);
      $past(hresetn) && $past(clock_control_word.core_source_select) == s
         && $past(clock_control_word.vco_range_select) == r |-> core_div_ratio == q && core_from_loop;
   endproperty

   chk_ratio_full: assert property (p_ratio(2'b11, 1'b1, 3'h1)) else $error("ratio not 1");
   chk_ratio_vco_half: assert property (p_ratio(2'b11, 1'b0, 3'h2)) else $error("ratio not 2");
   chk_ratio_sel_half: assert property (p_ratio(2'b01, 1'b1, 3'h2)) else $error("ratio not 2");
   chk_ratio_quarter: assert property (p_ratio(2'b01, 1'b0, 3'h4)) else $error("ratio not 4");
   chk_ratio_ref: assert property ($past(hresetn) && !$past(clock_control_word.core_source_select[0])
      |-> core_div_ratio == 3'h0 && !core_from_loop) else $error("core not on reference");
endmodule

bind pcc_top pcc_top_chk #(.MEAS_LEN(MEAS_LEN)) u_chk (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
   .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
   .reference_input_clock(reference_input_clock), .clock_control_word(clock_control_word),
   .core_div_ratio(core_div_ratio), .core_from_loop(core_from_loop)
);

// >>> verilog/pcc_pkg.sv
package pcc_pkg;

   // ***************************************************************
   // register map and fields
   // ***************************************************************
   localparam int unsigned ADDR_W        = 8;
   localparam logic [7:0]  OFF_CTRL      = 8'h00;
   localparam logic [7:0]  OFF_STATUS    = 8'h04;
   localparam logic [7:0]  OFF_REF_KHZ   = 8'h08;
   localparam logic [7:0]  OFF_DIV_KHZ   = 8'h0C;
   localparam logic [7:0]  OFF_LOOP_KHZ  = 8'h10;
   localparam logic [7:0]  OFF_CORE_KHZ  = 8'h14;

   localparam int unsigned POS_PREDIV    = 0;
   localparam int unsigned POS_MULT      = 4;
   localparam int unsigned POS_RANGE     = 12;
   localparam int unsigned POS_SOURCE    = 13;
   localparam int unsigned CTRL_W        = 15;

   localparam logic [3:0]  PREDIV_MAX    = 4'h9;
   localparam logic [1:0]  SRC_VCO       = 2'b11;
   localparam logic [1:0]  SRC_VCO_HALF  = 2'b01;

   // status bit positions
   localparam int unsigned ST_VALID      = 0;
   localparam int unsigned ST_DIVIN_BAD  = 1;
   localparam int unsigned ST_LOOP_BAD   = 2;
   localparam int unsigned ST_CORE_OVER  = 3;
   localparam int unsigned ST_REF_BAD    = 4;
   localparam int unsigned ST_W          = 5;

   // ***************************************************************
   // reset values
   // ***************************************************************
   localparam logic [3:0]  RST_PREDIV    = 4'h0;
   localparam logic [7:0]  RST_MULT      = 8'h00;
   localparam logic        RST_RANGE     = 1'b1;
   localparam logic [1:0]  RST_SOURCE    = 2'b00;

   // ***************************************************************
   // frequency windows, kHz
   // ***************************************************************
   localparam logic [31:0] DIVIN_MIN_KHZ = 32'h0000_2710;  // 10 MHz
   localparam logic [31:0] DIVIN_MAX_KHZ = 32'h0000_61A8;  // 25 MHz
   localparam logic [31:0] LOOP_MIN_KHZ  = 32'h0004_0F10;  // 266 MHz
   localparam logic [31:0] LOOP_MAX_KHZ  = 32'h0008_1E20;  // 532 MHz
   localparam logic [31:0] CORE_MAX_KHZ  = 32'h0004_93E0;  // 300 MHz
   localparam logic [31:0] REF_MAX_KHZ   = 32'h0001_86A0;  // 100 MHz

   // ***************************************************************
   // timing
   // ***************************************************************
   localparam int unsigned CLK_MHZ       = 125;
   localparam int unsigned MEAS_WIN_US   = 1000;
   // a 1 ms gate makes every edge count read directly in kHz
   localparam int unsigned MEAS_CYCLES   = MEAS_WIN_US * CLK_MHZ;

   typedef struct packed {
      logic [1:0] core_source_select;
      logic       vco_range_select;
      logic [7:0] loop_multiply_field;
      logic [3:0] input_predivide_field;
   } pcc_ctrl_t;

   localparam pcc_ctrl_t RST_CTRL = '{RST_SOURCE, RST_RANGE, RST_MULT, RST_PREDIV};

endpackage

// >>> verilog/pcc_prediv.sv
`timescale 1ns/100ps
module pcc_prediv (
   input  wire logic       hclk,       // system clock
   input  wire logic       hresetn,    // async reset, active low
   input  wire logic       ref_rise,   // one pulse per reference rising edge
   input  wire logic [3:0] div_code,   // predivide code
   output logic            div_tick    // one pulse per divided period
);
   import pcc_pkg::*;

   typedef struct packed {
      logic [3:0] cnt;
      logic       tick;
   } pcc_prediv_st_t;

   pcc_prediv_st_t st_reg;
   pcc_prediv_st_t st_next;

   always_comb begin
      st_next      = st_reg;
      st_next.tick = 1'b0;
      if (ref_rise) begin
         // a code lowered below the count restarts cleanly
         if (st_reg.cnt >= div_code) begin
            st_next.cnt  = 4'h0;
            st_next.tick = 1'b1;
         end else begin
            st_next.cnt = st_reg.cnt + 4'h1;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign div_tick = st_reg.tick;
endmodule

// >>> verilog/pcc_top.sv
// Local design decisions: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/100ps
module pcc_top #(
   parameter int unsigned MEAS_LEN = pcc_pkg::MEAS_CYCLES   // gate length in hclk cycles
) (
   input  wire logic                  hclk,                   // system clock
   input  wire logic                  hresetn,                // async reset, active low
   input  wire logic                  hsel,                   // slave select
   input  wire logic [31:0]           haddr,                  // byte address
   input  wire logic [1:0]            htrans,                 // transfer type
   input  wire logic                  hwrite,                 // write when high
   input  wire logic [2:0]            hsize,                  // transfer size
   input  wire logic [31:0]           hwdata,                 // write data
   input  wire logic                  hready,                 // bus ready in
   output logic                       hreadyout,              // slave ready
   output logic                       hresp,                  // always okay
   output logic [31:0]                hrdata,                 // read data
   input  wire logic                  reference_input_clock,  // reference clock pin
   output pcc_pkg::pcc_ctrl_t         clock_control_word,     // to the loop macro
   output logic [2:0]                 core_div_ratio,         // loop to core, 0 = ref
   output logic                       core_from_loop          // core runs off oscillator
);
   import pcc_pkg::*;

   // ***************************************************************
   // state
   // ***************************************************************
   typedef struct packed {
      pcc_ctrl_t         ctrl;
      logic              wr_pend;
      logic [ADDR_W-1:0] wr_addr;
      logic [31:0]       rdata;
      logic              ready;
      logic [2:0]        ref_s;
      logic [31:0]       win;
      logic [31:0]       ref_cnt;
      logic [31:0]       div_cnt;
      logic [31:0]       ref_khz;
      logic [31:0]       div_khz;
      logic [31:0]       loop_khz;
      logic [31:0]       core_khz;
      logic [ST_W-1:0]   status;
      logic [2:0]        ratio;
      logic              from_loop;
   } pcc_st_t;

   pcc_st_t st_reg;
   pcc_st_t st_next;

   logic ref_rise;
   logic div_tick;

   // first sync stage feeds only the second; edge uses stages two and three
   assign ref_rise = st_reg.ref_s[1] & ~st_reg.ref_s[2];

   pcc_prediv u_prediv (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .ref_rise (ref_rise),
      .div_code (st_reg.ctrl.input_predivide_field),
      .div_tick (div_tick)
   );

   // ***************************************************************
   // helpers
   // ***************************************************************
   // codes past nine have no divider behind them, so they saturate
   function automatic pcc_ctrl_t clean_ctrl(input logic [31:0] w);
      pcc_ctrl_t c;
      c = pcc_ctrl_t'(w[CTRL_W-1:0]);
      if (c.input_predivide_field > PREDIV_MAX) begin
         c.input_predivide_field = PREDIV_MAX;
      end
      return c;
   endfunction

   function automatic logic [31:0] read_mux(input logic [ADDR_W-1:0] a,
                                            input pcc_ctrl_t c,
                                            input pcc_st_t s);
      logic [31:0] d;
      d = 32'h0000_0000;
      case (a)
         OFF_CTRL:     d = {{(32-CTRL_W){1'b0}}, c};
         OFF_STATUS:   d = {{(32-ST_W){1'b0}}, s.status};
         OFF_REF_KHZ:  d = s.ref_khz;
         OFF_DIV_KHZ:  d = s.div_khz;
         OFF_LOOP_KHZ: d = s.loop_khz;
         OFF_CORE_KHZ: d = s.core_khz;
         default:      d = 32'h0000_0000;
      endcase
      return d;
   endfunction

   // ***************************************************************
   // next state
   // ***************************************************************
   always_comb begin
      logic [31:0] vco;
      logic [31:0] core;
      logic [31:0] ref_lo;
      logic [31:0] ref_hi;
      logic [31:0] div_n;
      logic        top_ok;
      vco    = 32'h0000_0000;
      core   = 32'h0000_0000;
      ref_lo = 32'h0000_0000;
      ref_hi = 32'h0000_0000;
      div_n  = 32'h0000_0000;
      top_ok = 1'b0;

      st_next       = st_reg;
      st_next.ready = 1'b1;
      st_next.ref_s = {st_reg.ref_s[1:0], reference_input_clock};

      // data phase of a write
      st_next.wr_pend = 1'b0;
      if (st_reg.wr_pend && st_reg.wr_addr == OFF_CTRL) begin
         st_next.ctrl = clean_ctrl(hwdata);
      end

      // address phase; a read right after a write sees the new word
      top_ok = (haddr[31:ADDR_W] == '0) && (haddr[1:0] == 2'b00);
      if (hsel && htrans[1] && hready) begin
         if (hwrite) begin
            st_next.wr_pend = top_ok;
            st_next.wr_addr = haddr[ADDR_W-1:0];
         end else begin
            st_next.rdata = top_ok ? read_mux(haddr[ADDR_W-1:0], st_next.ctrl, st_reg)
                                   : 32'h0000_0000;
         end
      end

      // frequency gate
      if (st_reg.win >= 32'(MEAS_LEN - 1)) begin
         st_next.win     = 32'h0000_0000;
         // an edge on the gate's last cycle still belongs to this gate
         st_next.ref_khz = st_reg.ref_cnt + {31'h0, ref_rise};
         st_next.div_khz = st_reg.div_cnt + {31'h0, div_tick};
         st_next.ref_cnt = 32'h0000_0000;
         st_next.div_cnt = 32'h0000_0000;
         st_next.status[ST_VALID] = 1'b1;
      end else begin
         st_next.win     = st_reg.win + 32'h0000_0001;
         st_next.ref_cnt = st_reg.ref_cnt + {31'h0, ref_rise};
         st_next.div_cnt = st_reg.div_cnt + {31'h0, div_tick};
      end

      // derived frequencies: loop one cycle behind the latched counts, core from the loop two cycles behind
      st_next.loop_khz = 32'(st_reg.div_khz
                         * (32'(st_reg.ctrl.loop_multiply_field) + 32'h0000_0001));
      vco = st_reg.ctrl.vco_range_select ? st_reg.loop_khz
                                         : {1'b0, st_reg.loop_khz[31:1]};
      st_next.ratio     = 3'h0;
      st_next.from_loop = 1'b0;
      case (st_reg.ctrl.core_source_select)
         SRC_VCO: begin
            core              = vco;
            st_next.from_loop = 1'b1;
            st_next.ratio     = st_reg.ctrl.vco_range_select ? 3'h1 : 3'h2;
         end
         SRC_VCO_HALF: begin
            core              = {1'b0, vco[31:1]};
            st_next.from_loop = 1'b1;
            st_next.ratio     = st_reg.ctrl.vco_range_select ? 3'h2 : 3'h4;
         end
         default: begin
            core = st_reg.ref_khz;
         end
      endcase
      st_next.core_khz = core;

      // window checks that software is expected to keep
      div_n  = 32'(st_reg.ctrl.input_predivide_field) + 32'h0000_0001;
      ref_lo = 32'(DIVIN_MIN_KHZ * div_n);
      ref_hi = 32'(DIVIN_MAX_KHZ * div_n);
      if (ref_hi > REF_MAX_KHZ) begin
         ref_hi = REF_MAX_KHZ;
      end
      st_next.status[ST_REF_BAD]   = (st_reg.ref_khz < ref_lo)
                                   || (st_reg.ref_khz > ref_hi);
      st_next.status[ST_DIVIN_BAD] = (st_reg.div_khz < DIVIN_MIN_KHZ)
                                   || (st_reg.div_khz > DIVIN_MAX_KHZ);
      st_next.status[ST_LOOP_BAD]  = (st_reg.loop_khz < LOOP_MIN_KHZ)
                                   || (st_reg.loop_khz > LOOP_MAX_KHZ);
      st_next.status[ST_CORE_OVER] = st_reg.core_khz > CORE_MAX_KHZ;
   end

   // ***************************************************************
   // registers
   // ***************************************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_reg      <= '0;
         st_reg.ctrl <= RST_CTRL;
      end else begin
         st_reg <= st_next;
      end
   end

   // ***************************************************************
   // outputs
   // ***************************************************************
   assign hreadyout          = st_reg.ready;
   assign hresp              = 1'b0;
   assign hrdata             = st_reg.rdata;
   assign clock_control_word = st_reg.ctrl;
   assign core_div_ratio     = st_reg.ratio;
   assign core_from_loop     = st_reg.from_loop;

   // note: hclk at 125 MHz samples the reference pin, so measured kHz is only
   // exact below about 60 MHz reference; status then reads as a guide only
endmodule
